// >>> rtl/dcc_top.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dcc_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic COMP0_OUT_PIN,
  input wire logic COMP1_OUT_PIN,
  input wire dcc_pkg::dcc_ticks_t TICKS,
  input wire logic STOP_MODE,
  output logic COMP0_ON,
  output logic COMP1_ON,
  output logic COMP0_REF_SOURCE,
  output logic [3:0] COMP0_REF_CODE,
  output logic [3:0] COMP1_REF_CODE,
  output logic COMP_IRQ
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic comp0_on_q;
  logic comp1_on_q;
  logic [4:0] cfg0_q;
  logic [3:0] cfg1_q;
  logic [3:0] ref0_q;
  logic [3:0] ref1_q;
  logic [1:0] irq_en_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      comp0_on_q <= dcc_pkg::ENABLE_RESULT_RST[dcc_pkg::ON_BIT];
    end else if (WR && ADDR == dcc_pkg::COMP0_ENABLE_RESULT_OFS) begin
      comp0_on_q <= WDATA[dcc_pkg::ON_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      comp1_on_q <= dcc_pkg::ENABLE_RESULT_RST[dcc_pkg::ON_BIT];
    end else if (WR && ADDR == dcc_pkg::COMP1_ENABLE_RESULT_OFS) begin
      comp1_on_q <= WDATA[dcc_pkg::ON_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cfg0_q <= dcc_pkg::IRQ_SAMPLE_RST[4:0];
    end else if (WR && ADDR == dcc_pkg::COMP0_IRQ_SAMPLE_REF_OFS) begin
      cfg0_q <= WDATA[4:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cfg1_q <= dcc_pkg::IRQ_SAMPLE_RST[3:0];
    end else if (WR && ADDR == dcc_pkg::COMP1_IRQ_SAMPLE_OFS) begin
      cfg1_q <= WDATA[3:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ref0_q <= dcc_pkg::REF_CODE_RST;
    end else if (WR && ADDR == dcc_pkg::COMP0_REF_LEVEL_OFS) begin
      ref0_q <= WDATA[3:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ref1_q <= dcc_pkg::REF_CODE_RST;
    end else if (WR && ADDR == dcc_pkg::COMP1_REF_LEVEL_OFS) begin
      ref1_q <= WDATA[3:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_en_q <= 2'h0;
    end else if (WR && ADDR == dcc_pkg::IRQ_ENABLE_OFS) begin
      irq_en_q <= WDATA[1:0];
    end
  end

  assign COMP0_ON = comp0_on_q;
  assign COMP1_ON = comp1_on_q;
  assign COMP0_REF_SOURCE = cfg0_q[dcc_pkg::REF_SOURCE_BIT];
  assign COMP0_REF_CODE = ref0_q;
  assign COMP1_REF_CODE = ref1_q;

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  logic [1:0] pin_s;
  logic res0_q;
  logic res1_q;

  dcc_sync #(.WIDTH(2)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .d({COMP1_OUT_PIN, COMP0_OUT_PIN}),
    .q(pin_s)
  );

  // Held while off: the analogue output is meaningless then
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      res0_q <= 1'b0;
      res1_q <= 1'b0;
    end else begin
      if (comp0_on_q) res0_q <= pin_s[0];
      if (comp1_on_q) res1_q <= pin_s[1];
    end
  end

  // ----------------------------------------
  // Edge detection per channel
  // ----------------------------------------
  logic [1:0] hit;
  dcc_pkg::dcc_chan_cfg_t ch_cfg [2];
  logic [1:0] res_vec;

  assign ch_cfg[0] = dcc_pkg::dcc_chan_cfg_t'({cfg0_q[1:0], cfg0_q[3:2]});
  assign ch_cfg[1] = dcc_pkg::dcc_chan_cfg_t'({cfg1_q[1:0], cfg1_q[3:2]});
  assign res_vec = {res1_q, res0_q};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      dcc_edge u_edge (
        .clk(CLK),
        .reset(RESET),
        .level(res_vec[gi]),
        .cfg(ch_cfg[gi]),
        .ticks(TICKS),
        .stop_mode(STOP_MODE),
        .edge_hit(hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [1:0] status_q;
  logic [1:0] clr;

  assign clr = (WR && ADDR == dcc_pkg::IRQ_CLEAR_OFS) ? WDATA[1:0] : 2'h0;

  // Set wins over a same-cycle clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (status_q & ~clr) | hit;
    end
  end

  assign COMP_IRQ = |(status_q & irq_en_q);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    case (ADDR)
      dcc_pkg::COMP0_ENABLE_RESULT_OFS: rdata_d = {6'h00, res0_q, comp0_on_q};
      dcc_pkg::COMP1_ENABLE_RESULT_OFS: rdata_d = {6'h00, res1_q, comp1_on_q};
      dcc_pkg::COMP0_IRQ_SAMPLE_REF_OFS: rdata_d = {3'h0, cfg0_q};
      dcc_pkg::COMP1_IRQ_SAMPLE_OFS: rdata_d = {4'h0, cfg1_q};
      dcc_pkg::COMP0_REF_LEVEL_OFS: rdata_d = {4'h0, ref0_q};
      dcc_pkg::COMP1_REF_LEVEL_OFS: rdata_d = {4'h0, ref1_q};
      dcc_pkg::IRQ_STATUS_OFS: rdata_d = {6'h00, status_q};
      dcc_pkg::IRQ_ENABLE_OFS: rdata_d = {6'h00, irq_en_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rdata_d;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_freeze0;
    @(posedge CLK) disable iff (RESET)
      !comp0_on_q |=> $stable(res0_q);
  endproperty
  a_freeze0: assert property (p_freeze0) else $error("result 0 moved while off");

  property p_freeze1;
    @(posedge CLK) disable iff (RESET)
      !comp1_on_q |=> $stable(res1_q);
  endproperty
  a_freeze1: assert property (p_freeze1) else $error("result 1 moved while off");

  property p_track0;
    @(posedge CLK) disable iff (RESET)
      comp0_on_q |=> (res0_q == $past(pin_s[0]));
  endproperty
  a_track0: assert property (p_track0) else $error("result 0 not tracking");

  property p_enable_write;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP1_ENABLE_RESULT_OFS) |=> (COMP1_ON == $past(WDATA[0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("comp1 enable lost");

  property p_on0;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP0_ENABLE_RESULT_OFS) |=> (COMP0_ON == $past(WDATA[0]));
  endproperty
  a_on0: assert property (p_on0) else $error("comp0 enable lost");

  property p_hit_sets;
    @(posedge CLK) disable iff (RESET)
      hit[0] |=> status_q[0];
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("hit not latched");

  property p_irq_level;
    @(posedge CLK) disable iff (RESET)
      (status_q[1] && irq_en_q[1]) |-> COMP_IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");

  property p_ref_src;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP0_IRQ_SAMPLE_REF_OFS) |=> (COMP0_REF_SOURCE == $past(WDATA[4]));
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("ref source lost");

  property p_track1;
    @(posedge CLK) disable iff (RESET)
      comp1_on_q |=> (res1_q == $past(pin_s[1]));
  endproperty
  a_track1: assert property (p_track1) else $error("result 1 not tracking");

  property p_hit_sets1;
    @(posedge CLK) disable iff (RESET)
      hit[1] |=> status_q[1];
  endproperty
  a_hit_sets1: assert property (p_hit_sets1) else $error("hit 1 not latched");

  property p_irq_level0;
    @(posedge CLK) disable iff (RESET)
      (status_q[0] && irq_en_q[0]) |-> COMP_IRQ;
  endproperty
  a_irq_level0: assert property (p_irq_level0) else $error("irq 0 not raised");

  property p_irq_quiet;
    @(posedge CLK) disable iff (RESET)
      ((status_q & irq_en_q) == 2'h0) |-> !COMP_IRQ;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enabled status");

  property p_sticky0;
    @(posedge CLK) disable iff (RESET)
      (status_q[0] && !clr[0]) |=> status_q[0];
  endproperty
  a_sticky0: assert property (p_sticky0) else $error("status 0 dropped");

  property p_sticky1;
    @(posedge CLK) disable iff (RESET)
      (status_q[1] && !clr[1]) |=> status_q[1];
  endproperty
  a_sticky1: assert property (p_sticky1) else $error("status 1 dropped");

  property p_no_ghost0;
    @(posedge CLK) disable iff (RESET)
      (!hit[0] && !status_q[0]) |=> !status_q[0];
  endproperty
  a_no_ghost0: assert property (p_no_ghost0) else $error("status 0 set without edge");

  property p_no_ghost1;
    @(posedge CLK) disable iff (RESET)
      (!hit[1] && !status_q[1]) |=> !status_q[1];
  endproperty
  a_no_ghost1: assert property (p_no_ghost1) else $error("status 1 set without edge");

  property p_rdata_idle;
    @(posedge CLK) disable iff (RESET)
      !RD |=> (RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

  property p_read0;
    @(posedge CLK) disable iff (RESET)
      (RD && ADDR == dcc_pkg::COMP0_ENABLE_RESULT_OFS) |=>
        (RDATA == {6'h00, $past(res0_q), $past(comp0_on_q)});
  endproperty
  a_read0: assert property (p_read0) else $error("result 0 read wrong");

  property p_read1;
    @(posedge CLK) disable iff (RESET)
      (RD && ADDR == dcc_pkg::COMP1_ENABLE_RESULT_OFS) |=>
        (RDATA == {6'h00, $past(res1_q), $past(comp1_on_q)});
  endproperty
  a_read1: assert property (p_read1) else $error("result 1 read wrong");

  property p_ref0_write;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP0_REF_LEVEL_OFS) |=> (COMP0_REF_CODE == $past(WDATA[3:0]));
  endproperty
  a_ref0_write: assert property (p_ref0_write) else $error("ref level 0 lost");

  property p_ref1_write;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP1_REF_LEVEL_OFS) |=> (COMP1_REF_CODE == $past(WDATA[3:0]));
  endproperty
  a_ref1_write: assert property (p_ref1_write) else $error("ref level 1 lost");

  property p_ref0_hold;
    @(posedge CLK) disable iff (RESET)
      !(WR && ADDR == dcc_pkg::COMP0_REF_LEVEL_OFS) |=> $stable(COMP0_REF_CODE);
  endproperty
  a_ref0_hold: assert property (p_ref0_hold) else $error("ref level 0 moved");

  property p_on0_hold;
    @(posedge CLK) disable iff (RESET)
      !(WR && ADDR == dcc_pkg::COMP0_ENABLE_RESULT_OFS) |=> $stable(COMP0_ON);
  endproperty
  a_on0_hold: assert property (p_on0_hold) else $error("comp0 enable moved");

  property p_on1_hold;
    @(posedge CLK) disable iff (RESET)
      !(WR && ADDR == dcc_pkg::COMP1_ENABLE_RESULT_OFS) |=> $stable(COMP1_ON);
  endproperty
  a_on1_hold: assert property (p_on1_hold) else $error("comp1 enable moved");

  property p_mode0;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP0_IRQ_SAMPLE_REF_OFS) |=> (cfg0_q[3:0] == $past(WDATA[3:0]));
  endproperty
  a_mode0: assert property (p_mode0) else $error("comp0 mode lost");

  property p_mode1;
    @(posedge CLK) disable iff (RESET)
      (WR && ADDR == dcc_pkg::COMP1_IRQ_SAMPLE_OFS) |=> (cfg1_q == $past(WDATA[3:0]));
  endproperty
  a_mode1: assert property (p_mode1) else $error("comp1 mode lost");

endmodule : dcc_top
`default_nettype wire

// >>> pkg/dcc_pkg.sv
// Functional notes
// - Comparator 0 on while enable bit set
// - Comparator 0 result flag at bit one
// - Off comparator freezes its last result
// - Two-bit field picks interrupt edge mode
// - Sampling field picks unsampled or tick source
// - Reference select: internal zero, external one
// - Four-bit reference level, resets to eight
// - No sampling while in stop mode; unsampled channels still capture each cycle
// - Comparator 1 has its own enable
// - Interrupt raised on chosen result edge
package dcc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] COMP0_ENABLE_RESULT_OFS = 16'hf950;
  localparam logic [15:0] COMP0_IRQ_SAMPLE_REF_OFS = 16'hf951;
  localparam logic [15:0] COMP0_REF_LEVEL_OFS = 16'hf952;
  localparam logic [15:0] COMP1_ENABLE_RESULT_OFS = 16'hf954;
  localparam logic [15:0] COMP1_IRQ_SAMPLE_OFS = 16'hf955;
  localparam logic [15:0] COMP1_REF_LEVEL_OFS = 16'hf956;
  localparam logic [15:0] IRQ_STATUS_OFS = 16'hf958;
  localparam logic [15:0] IRQ_CLEAR_OFS = 16'hf959;
  localparam logic [15:0] IRQ_ENABLE_OFS = 16'hf95a;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ON_BIT = 0;
  localparam int RESULT_BIT = 1;
  localparam int EDGE_LSB = 0;
  localparam int SAMPLE_LSB = 2;
  localparam int REF_SOURCE_BIT = 4;
  localparam int REF_CODE_LSB = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ENABLE_RESULT_RST = 8'h00;
  localparam logic [7:0] IRQ_SAMPLE_RST = 8'h00;
  localparam logic [3:0] REF_CODE_RST = 4'h8;

  // ----------------------------------------
  // Encodings and timing
  // ----------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int SETTLE_MS = 3;
  localparam int CLK_HZ = 50000000;
  localparam int SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    DCC_SAMP_NONE,
    DCC_SAMP_16K,
    DCC_SAMP_128K,
    DCC_SAMP_256K
  } dcc_samp_t;

  typedef struct packed {
    logic [1:0] edge_sel;
    dcc_samp_t sample_sel;
  } dcc_chan_cfg_t;

  typedef struct packed {
    logic tick_16k;
    logic tick_128k;
    logic tick_256k;
  } dcc_ticks_t;

endpackage : dcc_pkg

// >>> rtl/dcc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("dcc_sync: WIDTH must be at least one");
    end
  end

  // First stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : dcc_sync
`default_nettype wire

// >>> rtl/dcc_edge.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic level,
  input wire dcc_pkg::dcc_chan_cfg_t cfg,
  input wire dcc_pkg::dcc_ticks_t ticks,
  input wire logic stop_mode,
  output logic edge_hit
);

  logic tick_sel;
  logic src_q;
  logic prev_q;
  logic prime_q;
  logic capture;

  always_comb begin
    case (cfg.sample_sel)
      dcc_pkg::DCC_SAMP_16K: tick_sel = ticks.tick_16k;
      dcc_pkg::DCC_SAMP_128K: tick_sel = ticks.tick_128k;
      dcc_pkg::DCC_SAMP_256K: tick_sel = ticks.tick_256k;
      default: tick_sel = 1'b0;
    endcase
  end

  // Ticks halt in stop, so only unsampled channels still capture there
  assign capture = (cfg.sample_sel == dcc_pkg::DCC_SAMP_NONE) ? 1'b1
                 : (tick_sel && !stop_mode);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_q <= 1'b0;
      prev_q <= 1'b0;
      prime_q <= 1'b0;
    end else if (capture) begin
      src_q <= level;
      prev_q <= src_q;
      prime_q <= 1'b1;
    end
  end

  logic cap_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_q <= 1'b0;
    end else begin
      cap_q <= capture;
    end
  end

  // Compare successive captures only once after each capture
  always_comb begin
    edge_hit = 1'b0;
    if (cap_q && prime_q) begin
      case (cfg.edge_sel)
        dcc_pkg::EDGE_FALL: edge_hit = prev_q && !src_q;
        dcc_pkg::EDGE_RISE: edge_hit = !prev_q && src_q;
        dcc_pkg::EDGE_BOTH: edge_hit = prev_q ^ src_q;
        default: edge_hit = 1'b0;
      endcase
    end
  end

  property p_no_hit_disabled;
    @(posedge clk) disable iff (reset)
      (cfg.edge_sel == dcc_pkg::EDGE_NONE) |-> !edge_hit;
  endproperty
  a_no_hit_disabled: assert property (p_no_hit_disabled) else $error("edge with irq off");

  property p_stop_no_sample;
    @(posedge clk) disable iff (reset)
      (stop_mode && cfg.sample_sel != dcc_pkg::DCC_SAMP_NONE) |=> $stable(src_q);
  endproperty
  a_stop_no_sample: assert property (p_stop_no_sample) else $error("sampled in stop");

endmodule : dcc_edge
`default_nettype wire

// >>> test/dcc_comp_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_comp_model (
  input wire logic clk,
  input wire logic on0,
  input wire logic on1,
  input wire logic ref_src0,
  input wire logic [3:0] ref_code0,
  input wire logic [3:0] ref_code1,
  input wire logic [15:0] p0_mv,
  input wire logic [15:0] m0_mv,
  input wire logic [15:0] p1_mv,
  output logic out0,
  output logic out1
);
  // ----------------------------------------
  // Analogue cores
  // ----------------------------------------
  logic [15:0] ref0;
  logic [15:0] ref1;
  assign ref0 = ref_src0 ? m0_mv : 16'h0032 * (16'(ref_code0) + 16'h0001);
  assign ref1 = 16'h0032 * (16'(ref_code1) + 16'h0001);
  initial begin
    out0 = 1'b0;
    out1 = 1'b0;
  end
  // Unpowered core output is garbage, so it toggles
  always @(posedge clk) begin
    out0 <= on0 ? (p0_mv > ref0) : ~out0;
    out1 <= on1 ? (p1_mv > ref1) : ~out1;
  end
endmodule : dcc_comp_model
`default_nettype wire

// >>> test/dcc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dcc_top_bench;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic pin0;
  logic pin1;
  dcc_pkg::dcc_ticks_t TICKS = 3'h0;
  logic STOP_MODE = 1'b0;
  logic on0;
  logic on1;
  logic src0;
  logic [3:0] code0;
  logic [3:0] code1;
  logic COMP_IRQ;
  logic [15:0] p0 = 16'h0064;
  logic [15:0] m0 = 16'h0000;
  logic [15:0] p1 = 16'h0064;
  int fail_count = 0;
  int checks = 0;
  always #10 CLK = ~CLK;
  dcc_top i_dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .COMP0_OUT_PIN(pin0), .COMP1_OUT_PIN(pin1), .TICKS(TICKS),
    .STOP_MODE(STOP_MODE), .COMP0_ON(on0), .COMP1_ON(on1), .COMP0_REF_SOURCE(src0),
    .COMP0_REF_CODE(code0), .COMP1_REF_CODE(code1), .COMP_IRQ(COMP_IRQ));
  dcc_comp_model i_model (.clk(CLK), .on0(on0), .on1(on1), .ref_src0(src0),
    .ref_code0(code0), .ref_code1(code1), .p0_mv(p0), .m0_mv(m0), .p1_mv(p1),
    .out0(pin0), .out1(pin1));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Only the low byte differs across the map
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= {8'hf9, a};
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= {8'hf9, a};
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  task automatic tick(input logic [2:0] t);
    @(posedge CLK);
    TICKS <= t;
    @(posedge CLK);
    TICKS <= 3'h0;
  endtask : tick
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    rd(8'h50, 8'h00);
    rd(8'h51, 8'h00);
    rd(8'h52, 8'h08);
    rd(8'h54, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h08);
    rd(8'h5a, 8'h00);
    chk({code1, code0}, 8'h88);
    wr(8'h51, 8'hff);
    rd(8'h51, 8'h1f);
    chk({7'h0, src0}, 8'h01);
    wr(8'h51, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h0f);
    wr(8'h55, 8'h00);
    wr(8'h53, 8'hff);
    rd(8'h53, 8'h00);
    wr(8'h50, 8'h03);
    #1 chk({7'h0, on0}, 8'h01);
    p0 <= 16'h0384;
    // Model settles at once; a short wait stands in
    cyc(8);
    rd(8'h50, 8'h03);
    p0 <= 16'h0064;
    cyc(8);
    rd(8'h50, 8'h01);
    p0 <= 16'h0384;
    cyc(8);
    wr(8'h50, 8'h00);
    #1 chk({7'h0, on0}, 8'h00);
    p0 <= 16'h0064;
    cyc(8);
    rd(8'h50, 8'h02);
    wr(8'h50, 8'h01);
    p0 <= 16'h0258;
    m0 <= 16'h0384;
    wr(8'h51, 8'h10);
    cyc(8);
    rd(8'h50, 8'h01);
    wr(8'h51, 8'h00);
    cyc(8);
    rd(8'h50, 8'h03);
    p0 <= 16'h0050;
    wr(8'h52, 8'h00);
    cyc(8);
    rd(8'h50, 8'h03);
    wr(8'h52, 8'h01);
    cyc(8);
    rd(8'h50, 8'h01);
    wr(8'h52, 8'h08);
    wr(8'h54, 8'h01);
    p1 <= 16'h0384;
    cyc(8);
    rd(8'h54, 8'h03);
    wr(8'h55, 8'h01);
    wr(8'h5a, 8'h02);
    p1 <= 16'h0064;
    cyc(8);
    rd(8'h58, 8'h02);
    chk({7'h0, COMP_IRQ}, 8'h01);
    wr(8'h59, 8'h02);
    wr(8'h55, 8'h00);
    wr(8'h54, 8'h00);
    #1 chk({6'h0, on1, on0}, 8'h01);
    wr(8'h5a, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(8'h51, 8'(m));
      p0 <= 16'h0384;
      cyc(8);
      rd(8'h58, {7'h0, m[1]});
      chk({7'h0, COMP_IRQ}, {7'h0, m[1]});
      wr(8'h59, 8'h01);
      p0 <= 16'h0064;
      cyc(8);
      rd(8'h58, {7'h0, m[0]});
      wr(8'h59, 8'h01);
    end
    wr(8'h5a, 8'h00);
    p0 <= 16'h0384;
    cyc(8);
    rd(8'h58, 8'h01);
    chk({7'h0, COMP_IRQ}, 8'h00);
    wr(8'h5a, 8'h01);
    #1 chk({7'h0, COMP_IRQ}, 8'h01);
    rd(8'h59, 8'h00);
    wr(8'h59, 8'h01);
    #1 chk({7'h0, COMP_IRQ}, 8'h00);
    // Rising mode on each tick source in turn
    for (int s = 1; s < 4; s++) begin
      wr(8'h51, 8'(s * 4 + 2));
      p0 <= 16'h0064;
      cyc(8);
      tick(3'h4 >> (s - 1));
      tick(3'h4 >> (s - 1));
      wr(8'h59, 8'h01);
      p0 <= 16'h0384;
      cyc(8);
      rd(8'h58, 8'h00);
      tick(3'h4 >> (s % 3));
      cyc(3);
      rd(8'h58, 8'h00);
      @(posedge CLK) STOP_MODE <= 1'b1;
      tick(3'h4 >> (s - 1));
      cyc(3);
      rd(8'h58, 8'h00);
      @(posedge CLK) STOP_MODE <= 1'b0;
      tick(3'h4 >> (s - 1));
      cyc(3);
      rd(8'h58, 8'h01);
      wr(8'h59, 8'h01);
    end
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    tally_and_finish();
  end
endmodule : dcc_top_bench
`default_nettype wire
